// >>> design/phbc_control.sv
// Hazard, forwarding, stack alias and branch control for a 5-stage pipe.
// The decode stage presents its instruction summary; the block answers
// with registered stall, squash, forward and redirect controls.
module phbc_control
  import phbc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic dec_valid,          // Decode stage holds an instruction
  input wire logic dec_reads_a,        // Operand A is read
  input wire logic [3:0] dec_src_a,    // Operand A register
  input wire logic dec_reads_b,        // Operand B is read
  input wire logic [3:0] dec_src_b,    // Operand B register
  input wire logic dec_writes,         // Instruction writes a register
  input wire logic [3:0] dec_dest,     // Destination register
  input wire logic dec_is_load,        // Data arrives in memory stage
  input wire logic dec_first_format,   // First encoding format instruction
  input wire logic dec_mode_change,    // Changes privilege_mode_bit
  input wire logic dec_new_mode,       // Value it writes to the bit
  input wire logic dec_branch,         // Branch in decode
  input wire logic dec_delayed,        // Branch is the delayed kind
  input wire logic alu_branch_taken,   // Condition result of branch in alu
  input wire logic [31:0] alu_result,  // Result computed in alu_stage
  input wire logic [31:0] mem_load_data, // Data loaded in memory stage
  input wire logic exception_interrupt_trap_request, // Exception, interrupt or trap pending
  output logic stall,                  // Freeze fetch and decode
  output logic squash,                 // Cancel instruction now in decode
  output logic redirect,               // Fetch branch target this cycle
  output logic fwd_a,                  // Use fwd_data for operand A
  output logic fwd_b,                  // Use fwd_data for operand B
  output logic [31:0] fwd_data,        // Bypassed operand value
  output logic exception_interrupt_trap_accept, // Exception taken now
  output logic privilege_mode_bit,     // Selects stack behind register 15
  output logic stack_select_system     // Register 15 is system_stack_pointer
);
  // Stages after decode: alu, memory access, writeback
  phbc_stage_if alu_if ();
  phbc_stage_if mem_if ();
  phbc_stage_if wback_if ();

  // Registered controls plus mode and branch tracking for the alu stage
  typedef struct packed {
    logic stall;
    logic squash;
    logic redirect;
    logic fwd_a;
    logic fwd_b;
    logic [31:0] fwd_data;
    logic accept;             // Exception acceptance
    logic mode;
    logic alu_new_mode;       // Mode value carried by the changer in alu
    logic alu_branch;         // Branch now in alu_stage
    logic alu_delayed;        // That branch is delayed
    phbc_branch_e bstate;     // Delay slot still in flight
  } phbc_ctl_s;
  phbc_ctl_s st;
  phbc_ctl_s next_st;

  logic hit_a_alu;
  logic hit_b_alu;
  logic hit_a_mem;
  logic hit_b_mem;
  logic load_use;
  logic alias_lock;
  logic hazard;
  logic taken_plain;
  logic issue;

  // Match decode sources against in-flight destinations
  always_comb begin
    hit_a_alu = dec_reads_a && alu_if.writes && (alu_if.dest == dec_src_a);
    hit_b_alu = dec_reads_b && alu_if.writes && (alu_if.dest == dec_src_b);
    hit_a_mem = dec_reads_a && mem_if.writes && (mem_if.dest == dec_src_a);
    hit_b_mem = dec_reads_b && mem_if.writes && (mem_if.dest == dec_src_b);
    // A load in alu has no data yet: wait exactly one cycle
    load_use = dec_valid && alu_if.is_load && (hit_a_alu || hit_b_alu);
    // Register 15 read or write, or first format, right after a mode change
    alias_lock = dec_valid && alu_if.mode_change &&
      (dec_first_format ||
       (dec_reads_a && dec_src_a == PHBC_STACK_ALIAS_INDEX) ||
       (dec_reads_b && dec_src_b == PHBC_STACK_ALIAS_INDEX) ||
       (dec_writes && dec_dest == PHBC_STACK_ALIAS_INDEX));
    taken_plain = st.alu_branch && !st.alu_delayed && alu_branch_taken;
    hazard = (load_use || alias_lock) && !taken_plain;
    issue = dec_valid && !hazard && !taken_plain;
  end

  // Later stages always advance; decode enters only when it issues
  phbc_stage u_alu (
    .clock(clock), .rstn(rstn), .kill(!issue),
    .in_valid(dec_valid), .in_writes(dec_writes), .in_is_load(dec_is_load),
    .in_dest(dec_dest), .in_data(PHBC_DATA_RESET),
    .in_mode_change(dec_mode_change), .out(alu_if.stage)
  );
  phbc_stage u_mem (
    .clock(clock), .rstn(rstn), .kill(1'b0),
    .in_valid(alu_if.valid), .in_writes(alu_if.writes), .in_is_load(alu_if.is_load),
    .in_dest(alu_if.dest), .in_data(alu_result),
    .in_mode_change(alu_if.mode_change), .out(mem_if.stage)
  );
  phbc_stage u_wback (
    .clock(clock), .rstn(rstn), .kill(1'b0),
    .in_valid(mem_if.valid), .in_writes(mem_if.writes), .in_is_load(mem_if.is_load),
    .in_dest(mem_if.dest),
    .in_data(mem_if.is_load ? mem_load_data : mem_if.data),
    .in_mode_change(1'b0), .out(wback_if.stage)
  ); // register file written from this stage

  // Next controls; outputs are registered so they apply next cycle
  always_comb begin
    next_st = st;
    next_st.stall = hazard;
    // Squash only the instruction behind a taken plain branch
    next_st.squash = taken_plain;
    // Target fetched the cycle after the branch resolves or its slot
    next_st.redirect = st.alu_branch && alu_branch_taken;
    next_st.alu_branch = issue && dec_branch;
    next_st.alu_delayed = issue && dec_branch && dec_delayed;
    // Forward to the instruction that will sit in decode next cycle:
    // alu producer when it issues, memory load data in the same cycle as the one stall
    next_st.fwd_a = 1'b0;
    next_st.fwd_b = 1'b0;
    next_st.fwd_data = st.fwd_data;
    if (load_use && !taken_plain) begin
      next_st.fwd_a = hit_a_alu;
      next_st.fwd_b = hit_b_alu;
      next_st.fwd_data = mem_load_data;
    end else if (issue && !alu_if.is_load && (hit_a_alu || hit_b_alu)) begin
      next_st.fwd_a = hit_a_alu;
      next_st.fwd_b = hit_b_alu;
      next_st.fwd_data = alu_result;
    end else if (issue && (hit_a_mem || hit_b_mem)) begin
      next_st.fwd_a = hit_a_mem;
      next_st.fwd_b = hit_b_mem;
      next_st.fwd_data = mem_if.is_load ? mem_load_data : mem_if.data;
    end
    // Mode bit takes effect as the changing instruction leaves alu
    // Capture the changer's own new value as it issues; decode moves on
    if (issue && dec_mode_change) begin
      next_st.alu_new_mode = dec_new_mode;
    end
    if (alu_if.mode_change) begin
      next_st.mode = st.alu_new_mode;
    end
    // Track the delay slot so exceptions wait for it to pass
    case (st.bstate)
      phbc_run: begin
        if (issue && dec_branch && dec_delayed) begin
          next_st.bstate = phbc_wait_slot;
        end
      end
      phbc_wait_slot: begin
        if (issue) begin
          next_st.bstate = phbc_run; // Slot has entered alu
        end
      end
      default: next_st.bstate = phbc_run;
    endcase
    // Block acceptance while a delayed branch or its slot is in flight
    next_st.accept = exception_interrupt_trap_request && st.bstate == phbc_run &&
      !(dec_valid && dec_branch && dec_delayed) && !st.alu_delayed;
  end

  // Synchronous active-low reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st <= '{stall: 1'b0, squash: 1'b0, redirect: 1'b0, fwd_a: 1'b0, fwd_b: 1'b0,
              fwd_data: PHBC_DATA_RESET, accept: 1'b0, mode: PHBC_MODE_RESET,
              alu_new_mode: PHBC_MODE_RESET, alu_branch: 1'b0, alu_delayed: 1'b0,
              bstate: phbc_run};
    end else begin
      st <= next_st;
    end
  end

  assign stall = st.stall;
  assign squash = st.squash;
  assign redirect = st.redirect;
  assign fwd_a = st.fwd_a;
  assign fwd_b = st.fwd_b;
  assign fwd_data = st.fwd_data;
  assign exception_interrupt_trap_accept = st.accept;
  assign privilege_mode_bit = st.mode;
  assign stack_select_system = !st.mode; // mode 0 selects system stack
endmodule : phbc_control

// >>> design/phbc_pkg.sv
// Overview of operation
// - Five overlapped stages, one instruction per cycle
// - Operands read in decode, written in writeback
// - Detect read-after-write hazards, stall when needed
// - Forward alu result to decode, no stall
// - Hold decode until load data available
// - Register fifteen maps system or user stack
// - Mode change then stack alias reference interlocks
// - Mode change then first-format instruction interlocks
// - Taken non-delayed branch squashes next instruction
// - Untaken non-delayed branch squashes nothing
// - Delayed branch always executes delay slot
// - Delayed branch costs one cycle either way
// - Taken delayed branch: slot, then target
// - No exception accepted during delayed branching
package phbc_pkg;
  localparam int unsigned PHBC_REG_BITS = 4;
  localparam logic [3:0] PHBC_STACK_ALIAS_INDEX = 4'hF;
  localparam logic PHBC_MODE_RESET = 1'h0;
  localparam logic [31:0] PHBC_DATA_RESET = 32'h0;
  typedef enum logic [1:0] {
    phbc_run,
    phbc_wait_slot
  } phbc_branch_e;
endpackage : phbc_pkg

// >>> design/phbc_stage.sv
// One pipeline latch of destination info; bubble when kill is high
module phbc_stage
  import phbc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic kill,
  input wire logic in_valid,
  input wire logic in_writes,
  input wire logic in_is_load,
  input wire logic [3:0] in_dest,
  input wire logic [31:0] in_data,
  input wire logic in_mode_change,
  phbc_stage_if.stage out
);
  typedef struct packed {
    logic valid;
    logic writes;
    logic is_load;
    logic [3:0] dest;
    logic [31:0] data;
    logic mode_change;
  } phbc_stage_s;
  phbc_stage_s st;
  phbc_stage_s next_st;

  // Bubble carries no write so later stages stay harmless
  always_comb begin
    next_st = '{in_valid, in_writes, in_is_load, in_dest, in_data, in_mode_change};
    if (kill || !in_valid) begin
      next_st.valid = 1'b0;
      next_st.writes = 1'b0;
      next_st.is_load = 1'b0;
      next_st.mode_change = 1'b0;
    end
  end

  // Synchronous active-low reset clears the stage
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out.valid = st.valid;
  assign out.writes = st.writes;
  assign out.is_load = st.is_load;
  assign out.dest = st.dest;
  assign out.data = st.data;
  assign out.mode_change = st.mode_change;
endmodule : phbc_stage

// >>> design/phbc_stage_if.sv
// Destination bookkeeping carried by a later pipeline stage
interface phbc_stage_if;
  logic valid;
  logic writes;
  logic is_load;
  logic [3:0] dest;
  logic [31:0] data;
  logic mode_change;
  modport stage (output valid, writes, is_load, dest, data, mode_change);
  modport user (input valid, writes, is_load, dest, data, mode_change);
endinterface : phbc_stage_if

// >>> verif/phbc_control_monitor.sv
// Watches the control outputs against the decode-stage summary
module phbc_control_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic dec_valid,
  input wire logic dec_reads_a,
  input wire logic [3:0] dec_src_a,
  input wire logic dec_writes,
  input wire logic [3:0] dec_dest,
  input wire logic dec_is_load,
  input wire logic dec_first_format,
  input wire logic dec_mode_change,
  input wire logic dec_branch,
  input wire logic dec_delayed,
  input wire logic alu_branch_taken,
  input wire logic stall,
  input wire logic squash,
  input wire logic redirect,
  input wire logic exception_interrupt_trap_accept,
  input wire logic privilege_mode_bit,
  input wire logic stack_select_system
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Stack alias follows the mode bit
  chk_stack_alias: assert property (stack_select_system == !privilege_mode_bit)
    else $error("stack alias wrong");
  // A squash only follows a taken branch, with a redirect
  chk_squash_cause: assert property (squash |-> redirect && $past(alu_branch_taken))
    else $error("stray squash");
  // Untaken condition leaves the stream alone
  chk_untaken_quiet: assert property (!alu_branch_taken |=> !squash && !redirect)
    else $error("untaken branch acted");
  // Load then dependent read must stall
  chk_load_stall: assert property (dec_valid && dec_is_load && dec_writes && !stall
    ##1 dec_valid && dec_reads_a && dec_src_a == $past(dec_dest) |=> stall)
    else $error("no load stall");
  // Interlocks cost exactly one cycle
  chk_one_stall: assert property (stall |=> !stall)
    else $error("stall too long");
  // Alu result dependency is bypassed without a stall
  chk_alu_bypass: assert property (dec_valid && dec_writes && !dec_is_load
    && !dec_mode_change && !stall ##1 dec_valid && dec_reads_a && !dec_first_format
    && dec_src_a != 4'hF && dec_src_a == $past(dec_dest) |=> !stall)
    else $error("needless stall");
  // Mode change then first-format instruction interlocks
  chk_format_lock: assert property (dec_valid && dec_mode_change && !stall
    ##1 dec_valid && dec_first_format |=> stall)
    else $error("no format interlock");
  // No exception taken while a delayed branch is in flight
  chk_eit_blocked: assert property (dec_valid && dec_branch && dec_delayed && !stall
    |=> !exception_interrupt_trap_accept [*2])
    else $error("exception in branch");
  cov_stall: cover property (stall);
  cov_squash: cover property (squash);
  cov_slot: cover property (redirect && !squash);
endmodule : phbc_control_monitor

bind phbc_control phbc_control_monitor mon (.clock, .rstn, .dec_valid, .dec_reads_a,
  .dec_src_a, .dec_writes, .dec_dest, .dec_is_load, .dec_first_format, .dec_mode_change,
  .dec_branch, .dec_delayed, .alu_branch_taken, .stall, .squash, .redirect,
  .exception_interrupt_trap_accept,
  .privilege_mode_bit, .stack_select_system);

// >>> verif/phbc_control_test.sv
module phbc_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] LD_DATA = 32'h5A5A0F0F; // Memory stage value
  localparam logic [31:0] ALU_DATA = 32'hC3C3A5A5; // Alu stage value
  logic clock = 1'b0, rstn = 1'b0, exception_interrupt_trap_request = 1'b0;
  logic [17:0] word;
  logic alu_branch_taken, stall, squash, redirect, fwd_a, fwd_b;
  logic exception_interrupt_trap_accept;
  logic privilege_mode_bit, stack_select_system;
  logic [31:0] fwd_data, fwd_seen;
  int err_count = 0, checks = 0, cycles = 0;
  int n_stall, n_squash, n_redir;
  int n_accept_at; // First cycle after release with acceptance, 0 if none
  always #12.5 clock = ~clock;
  phbc_stream sm (.clock, .rstn, .stall, .redirect, .word, .alu_branch_taken);
  phbc_control uut (.clock, .rstn, .dec_valid(word[0]), .dec_reads_a(word[1]),
    .dec_src_a(word[5:2]), .dec_reads_b(word[1]), .dec_src_b(word[5:2]),
    .dec_writes(word[6]), .dec_dest(word[10:7]), .dec_is_load(word[11]),
    .dec_first_format(word[12]), .dec_mode_change(word[13]), .dec_new_mode(word[14]),
    .dec_branch(word[15]), .dec_delayed(word[16]), .alu_branch_taken,
    .alu_result(ALU_DATA), .mem_load_data(LD_DATA), .exception_interrupt_trap_request,
    .stall, .squash, .redirect, .fwd_a, .fwd_b, .fwd_data,
    .exception_interrupt_trap_accept, .privilege_mode_bit,
    .stack_select_system);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic close_out;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Load four words, pulse reset, then tally the controls
  task automatic run(input logic [17:0] p0, p1, p2, p3, input logic exc);
    {sm.prog[0], sm.prog[1], sm.prog[2], sm.prog[3]} = {p0, p1, p2, p3};
    rstn = 1'b0;
    exception_interrupt_trap_request = exc;
    n_accept_at = 0;
    n_stall = 0;
    n_squash = 0;
    n_redir = 0;
    fwd_seen = 32'h0;
    repeat (2) @(posedge clock);
    #2 rstn = 1'b1;
    for (int k = 1; k <= 12; k++) begin
      @(posedge clock);
      #1 n_stall += int'(stall === 1'b1);
      if (exception_interrupt_trap_accept === 1'b1 && n_accept_at == 0) n_accept_at = k;
      n_squash += int'(squash === 1'b1);
      n_redir += int'(redirect === 1'b1);
      if (fwd_a === 1'b1) fwd_seen = fwd_data;
    end
  endtask : run
  // Branch of each kind; the slot must survive a delayed one
  task automatic branch(input logic [17:0] ins, input int sq, input int rd, input logic e);
    run(ins, 18'h00147, 18'h00001, 18'h00001, e);
    check(n_squash, sq);
    check(n_redir, rd);
    // Branch and slot decode in the first two cycles, so acceptance waits for the third
    check(n_accept_at, e ? 3 : 0);
  endtask : branch
  // Cycle ceiling well above the whole run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    #2 rstn = 1'b1;
    @(posedge clock);
    #1 check(stack_select_system, 1);
    // Load then dependent read: one bubble, loaded value bypassed
    run(18'h008C1, 18'h00147, 18'h00001, 18'h00001, 1'b0);
    check(n_stall, 1);
    check(fwd_seen, LD_DATA);
    // Alu result consumed at once, no bubble
    run(18'h000C1, 18'h00147, 18'h00001, 18'h00001, 1'b0);
    check(n_stall, 0);
    check(fwd_seen, ALU_DATA);
    // Mode set, then first-format instruction
    run(18'h06001, 18'h01001, 18'h00001, 18'h00001, 1'b0);
    check(n_stall, 1);
    check(privilege_mode_bit, 1);
    // Mode cleared, then stack alias reference
    run(18'h06001, 18'h00001, 18'h02001, 18'h0003F, 1'b0);
    check(n_stall, 1);
    check(stack_select_system, 1);
    branch(18'h28001, 1, 1, 1'b0);
    branch(18'h08001, 0, 0, 1'b0);
    branch(18'h38001, 0, 1, 1'b1);
    branch(18'h18001, 0, 0, 1'b1);
    close_out();
  end
endmodule : phbc_control_test

// >>> verif/phbc_stream.sv
// Instruction stream model: a small program image presented to decode
module phbc_stream (
  input wire logic clock,
  input wire logic rstn,
  input wire logic stall,
  input wire logic redirect,
  output logic [17:0] word,
  output logic alu_branch_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [17:0] prog [0:31]; // Program image, written by the bench
  logic [4:0] pc = 5'h00; // Decode index
  logic hold, jump, rst; // Controls seen at the edge
  initial for (int i = 0; i < 32; i++) prog[i] = 18'h00001;
  initial alu_branch_taken = 1'b0;
  assign word = prog[pc];
  // Sample at the edge, change a little later so nothing races
  always @(posedge clock) begin
    hold = stall;
    jump = redirect;
    rst = !rstn;
    #2;
    alu_branch_taken = !hold && word[15] && word[17];
    // Programs keep slots free of branches, loads and multi-cycle ops
    if (rst) pc = 5'h00;
    else if (jump) pc = 5'h14;
    else if (!hold) pc = pc + 5'h01;
  end
endmodule : phbc_stream
